// ---- src/scs_status_regs.sv ----
// Per-channel line status and special receive status register bank
//
// Implementation choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/100ps

module scs_status_regs (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Avalon-MM slave
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Receiver and transmitter state, same clock
	input wire logic rx_char_avail,
	input wire logic tx_entry_free,
	input wire logic tx_crc_busy,
	input wire logic tx_underrun,
	input wire logic baud_zero,
	input wire logic rx_break,
	input wire logic rx_abort,
	input wire logic rx_sync_found,
	input wire logic rx_open_flag,
	input wire logic rx_close_flag,
	input wire logic rx_char_done,
	input wire logic rx_char_err,
	input wire logic rx_head_overrun,
	input wire logic rx_overrun_read,
	// Modem and sync pins
	input wire logic cts_pin_n,
	input wire logic carrier_detect_pin_n,
	input wire logic sync_pin_n_in,
	output logic sync_pin_n_out,
	output logic sync_pin_oe,
	// Status outputs
	output logic interrupt_pending_flag
);
	logic [7:0] mode_ctrl;
	logic [7:0] ext_status_source_enable_reg;
	logic [7:0] sync_char_write_reg;
	logic [7:0] feature_enable_prime_reg;
	logic [7:0] last_cmd;
	logic [7:0] buffer_and_line_status;
	logic [7:0] special_receive_status;
	logic [2:0] pin_meta;
	logic [2:0] pin_sync;
	logic [2:0] src_latch;
	logic [2:0] src_live;
	logic [2:0] src_en, src_chg;
	logic [1:0] mode;
	logic wr_go, cmd_wr, ext_rd;
	logic cmd_rst_ext, cmd_abort, cmd_hunt, cmd_rst_und, cmd_err_rst;
	logic frozen, hunt, hunt_q, brk, brk_q, und, und_q, zc, zc_q, zc_defer;
	logic eof, crc_fe, ovr_latch;
	logic brk_evt, und_evt, hunt_evt, zc_evt, int_evt;
	logic [7:0] next_line, rd_mux;

	// Mode decode and write strobes; a write lands at the completing edge
	assign mode = mode_ctrl[scs_pkg::MC_MODE_LSB +: 2];
	assign wr_go = avs_write && !avs_waitrequest && avs_byteenable[0];
	assign cmd_wr = wr_go && avs_address == scs_pkg::OFS_COMMAND;
	assign ext_rd = feature_enable_prime_reg[scs_pkg::PR_EXT_READ];
	assign cmd_rst_ext = cmd_wr
		&& avs_writedata[2:0] == scs_pkg::SCS_CMD_RESET_EXT;
	assign cmd_abort = cmd_wr
		&& avs_writedata[2:0] == scs_pkg::SCS_CMD_SEND_ABORT;
	assign cmd_hunt = cmd_wr && avs_writedata[2:0] == scs_pkg::SCS_CMD_ENTER_HUNT;
	assign cmd_rst_und = cmd_wr
		&& avs_writedata[2:0] == scs_pkg::SCS_CMD_RESET_UNDERRUN;
	assign cmd_err_rst = cmd_wr
		&& avs_writedata[2:0] == scs_pkg::SCS_CMD_ERROR_RESET;

	// Bus handshake: one wait cycle, then an answer with waitrequest low
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end else if ((avs_read || avs_write) && avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
			avs_readdata <= avs_read ? {24'h00_0000, rd_mux} : 32'h0000_0000;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	// Read multiplexer; extended locations read zero when disabled
	always_comb begin
		rd_mux = 8'h00;
		case (avs_address)
			scs_pkg::OFS_LINE_STATUS: rd_mux = buffer_and_line_status;
			scs_pkg::OFS_SPECIAL_RX: rd_mux = special_receive_status;
			scs_pkg::OFS_SRC_ENABLE: rd_mux = ext_status_source_enable_reg;
			scs_pkg::OFS_MODE_CTRL: rd_mux = mode_ctrl;
			scs_pkg::OFS_PRIME_READBACK:
				rd_mux = ext_rd ? feature_enable_prime_reg : 8'h00;
			scs_pkg::OFS_RB_MODE: rd_mux = ext_rd ? mode_ctrl : 8'h00;
			scs_pkg::OFS_RB_SRC_ENABLE:
				rd_mux = ext_rd ? ext_status_source_enable_reg : 8'h00;
			scs_pkg::OFS_RB_SYNC_CHAR:
				rd_mux = ext_rd ? sync_char_write_reg : 8'h00;
			scs_pkg::OFS_RB_COMMAND: rd_mux = ext_rd ? last_cmd : 8'h00;
			default: rd_mux = 8'h00;
		endcase
	end

	// Writable registers; the sync-char address is steered by the pointer
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mode_ctrl <= scs_pkg::MC_RESET;
			ext_status_source_enable_reg <= scs_pkg::SE_RESET;
			sync_char_write_reg <= 8'h00;
			feature_enable_prime_reg <= scs_pkg::PR_RESET;
			last_cmd <= 8'h00;
		end else if (wr_go) begin
			case (avs_address)
				scs_pkg::OFS_MODE_CTRL: mode_ctrl <= avs_writedata[7:0];
				scs_pkg::OFS_SRC_ENABLE:
					ext_status_source_enable_reg <= avs_writedata[7:0];
				scs_pkg::OFS_COMMAND: last_cmd <= avs_writedata[7:0];
				scs_pkg::OFS_SYNC_CHAR: begin
					if (mode_ctrl[scs_pkg::MC_PRIME_PTR])
						feature_enable_prime_reg <= avs_writedata[7:0];
					else
						sync_char_write_reg <= avs_writedata[7:0];
				end
				default: ;
			endcase
		end
	end

	// Modem pins cross in from outside: two flops before any use
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_meta <= 3'b111;
			pin_sync <= 3'b111;
		end else begin
			pin_meta <= {sync_pin_n_in, carrier_detect_pin_n, cts_pin_n};
			pin_sync <= pin_meta;
		end
	end

	// Pin-driven sources: 0 clear-to-send, 1 carrier, 2 sync pin
	assign src_live = ~pin_sync;
	assign src_en[0] = ext_status_source_enable_reg[scs_pkg::SE_CTS];
	assign src_en[1] = ext_status_source_enable_reg[scs_pkg::SE_DCD];
	assign src_en[2] = ext_status_source_enable_reg[scs_pkg::SE_SYNC]
		&& ((mode == scs_pkg::SCS_MODE_ASYNC && !mode_ctrl[scs_pkg::MC_XTAL])
		|| mode == scs_pkg::SCS_MODE_EXT_SYNC);

	// One latch per pin source; disabled latches track the pin so enabling
	// never reports a condition that was already there
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_src
			assign src_chg[gi] = src_en[gi] && !interrupt_pending_flag
				&& src_live[gi] != src_latch[gi];
			always_ff @(posedge core_clk or posedge sys_rst) begin
				if (sys_rst)
					src_latch[gi] <= 1'b0;
				else if (!src_en[gi] || src_chg[gi])
					src_latch[gi] <= src_live[gi];
			end
		end
	endgenerate

	// Break or abort follows the receiver; other modes show zero
	always_comb begin
		case (mode)
			scs_pkg::SCS_MODE_ASYNC: brk = rx_break;
			scs_pkg::SCS_MODE_FRAME: brk = rx_abort;
			default: brk = 1'b0;
		endcase
	end

	// Hunt flag for character sync and frame modes
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			hunt <= 1'b1;
		else if (cmd_hunt || (mode == scs_pkg::SCS_MODE_FRAME
			&& !mode_ctrl[scs_pkg::MC_RX_EN]))
			hunt <= 1'b1;
		else if (mode == scs_pkg::SCS_MODE_CHAR_SYNC && rx_sync_found)
			hunt <= 1'b0;
		else if (mode == scs_pkg::SCS_MODE_FRAME && rx_open_flag)
			hunt <= 1'b0;
	end

	// Underrun latch: any set source wins over the clearing command
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			und <= 1'b1;
		else if (tx_underrun || cmd_abort || !mode_ctrl[scs_pkg::MC_TX_EN])
			und <= 1'b1;
		else if (cmd_rst_und)
			und <= 1'b0;
	end

	// Previous values for edge detection
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			hunt_q <= 1'b1;
			brk_q <= 1'b0;
			und_q <= 1'b1;
			zc_q <= 1'b0;
		end else begin
			hunt_q <= hunt;
			brk_q <= brk;
			und_q <= und;
			zc_q <= zc;
		end
	end

	// Interrupt causes; break edges count even while one is pending
	assign zc = ext_status_source_enable_reg[scs_pkg::SE_ZERO] && baud_zero;
	assign brk_evt = ext_status_source_enable_reg[scs_pkg::SE_BREAK]
		&& brk != brk_q;
	assign und_evt = ext_status_source_enable_reg[scs_pkg::SE_UNDERRUN]
		&& und && !und_q;
	assign hunt_evt = ext_status_source_enable_reg[scs_pkg::SE_SYNC]
		&& hunt != hunt_q && (mode == scs_pkg::SCS_MODE_CHAR_SYNC
		|| mode == scs_pkg::SCS_MODE_FRAME);
	assign zc_evt = (zc && !zc_q && !interrupt_pending_flag)
		|| (zc && cmd_rst_ext && (zc_defer || !zc_q));
	assign int_evt = (|src_chg) || brk_evt || und_evt || hunt_evt || zc_evt;

	// Zero count that arrives during service waits for the service to end
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			zc_defer <= 1'b0;
		else if (!zc || cmd_rst_ext)
			zc_defer <= 1'b0;
		else if (zc && !zc_q && interrupt_pending_flag)
			zc_defer <= 1'b1;
	end

	// Pending flag: a new cause in the clearing cycle keeps it set
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			interrupt_pending_flag <= 1'b0;
		else if (int_evt)
			interrupt_pending_flag <= 1'b1;
		else if (cmd_rst_ext)
			interrupt_pending_flag <= 1'b0;
	end

	// Line status image, assembled from latched or live sources
	always_comb begin
		next_line[7] = brk;
		next_line[6] = und;
		next_line[5] = src_en[0] ? src_latch[0] : src_live[0];
		next_line[3] = src_en[1] ? src_latch[1] : src_live[1];
		case (mode)
			scs_pkg::SCS_MODE_ASYNC:
				next_line[4] = mode_ctrl[scs_pkg::MC_XTAL] ? 1'b0
					: (src_en[2] ? src_latch[2] : src_live[2]);
			scs_pkg::SCS_MODE_EXT_SYNC:
				next_line[4] = src_en[2] ? src_latch[2] : src_live[2];
			default: next_line[4] = hunt;
		endcase
		next_line[2] = tx_entry_free && !tx_crc_busy;
		next_line[1] = zc;
		next_line[0] = rx_char_avail;
	end

	// Freeze spans the read beat of the line status register
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			frozen <= 1'b0;
		else
			frozen <= avs_read && avs_waitrequest
				&& avs_address == scs_pkg::OFS_LINE_STATUS;
	end

	// Image holds still while frozen so the answer matches one snapshot
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			buffer_and_line_status <= scs_pkg::LS_RESET;
		else if (!frozen)
			buffer_and_line_status <= next_line;
	end

	// End of frame, check/framing error and overrun latch
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			eof <= 1'b0;
			crc_fe <= 1'b0;
			ovr_latch <= 1'b0;
		end else begin
			if (mode != scs_pkg::SCS_MODE_FRAME)
				eof <= 1'b0;
			else if (rx_close_flag)
				eof <= 1'b1;
			else if (cmd_err_rst || rx_char_done)
				eof <= 1'b0;
			if (rx_char_done)
				crc_fe <= rx_char_err;
			else if (cmd_err_rst)
				crc_fe <= 1'b0;
			if (rx_overrun_read)
				ovr_latch <= 1'b1;
			else if (cmd_err_rst)
				ovr_latch <= 1'b0;
		end
	end

	// Special receive image; residue and all-sent bits read zero here
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			special_receive_status <= 8'h00;
		else
			special_receive_status <= {eof, crc_fe,
				ovr_latch || rx_head_overrun, 5'h00};
	end

	// Sync pin is an output only in character sync mode
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync_pin_oe <= 1'b0;
			sync_pin_n_out <= 1'b1;
		end else begin
			sync_pin_oe <= mode == scs_pkg::SCS_MODE_CHAR_SYNC;
			sync_pin_n_out <= !(mode == scs_pkg::SCS_MODE_CHAR_SYNC
				&& rx_sync_found);
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	chk_prime_steer: assert property (
		wr_go && avs_address == scs_pkg::OFS_SYNC_CHAR
		&& mode_ctrl[scs_pkg::MC_PRIME_PTR]
		|=> feature_enable_prime_reg == $past(avs_writedata[7:0])
		&& $stable(sync_char_write_reg))
		else $error("prime write misrouted");
	chk_ext_read_gate: assert property (
		avs_read && avs_waitrequest && !ext_rd
		&& avs_address == scs_pkg::OFS_RB_SRC_ENABLE |=> avs_readdata == 0)
		else $error("extended read visible while off");
	chk_freeze_hold: assert property (
		frozen |=> $stable(buffer_and_line_status))
		else $error("line status changed during read");
	chk_underrun_clear: assert property (
		$fell(und) |-> $past(cmd_rst_und))
		else $error("underrun cleared without command");
	chk_underrun_set: assert property (
		tx_underrun |=> und ##1 buffer_and_line_status[6])
		else $error("underrun not latched");
	chk_break_irq: assert property (
		brk_evt |=> interrupt_pending_flag)
		else $error("break edge did not interrupt");
	chk_hunt_frame: assert property (
		mode == scs_pkg::SCS_MODE_FRAME && !mode_ctrl[scs_pkg::MC_RX_EN]
		|=> hunt)
		else $error("hunt not set with receiver off");
	chk_rx_avail: assert property (
		!frozen ##1 !frozen |-> buffer_and_line_status[scs_pkg::LS_RX_AVAIL]
		== $past(rx_char_avail))
		else $error("rx available mismatch");
	chk_ovr_latch: assert property (
		rx_overrun_read ##1 !cmd_err_rst [*2] |=> special_receive_status[5])
		else $error("overrun not held");
	chk_wait_answer: assert property (
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
	cov_break_pulse: cover property (brk_evt ##[1:20] brk_evt);
	cov_zero_defer: cover property (zc_defer ##[1:50] zc_evt);
	cov_prime_read: cover property (ext_rd && avs_read
		&& avs_address == scs_pkg::OFS_PRIME_READBACK && !avs_waitrequest);
endmodule : scs_status_regs

// ---- pkg/scs_pkg.sv ----
// Constants for the serial channel status register block
package scs_pkg;
	// Register byte offsets on the Avalon-MM slave
	localparam logic [5:0] OFS_LINE_STATUS = 6'h00;
	localparam logic [5:0] OFS_SPECIAL_RX = 6'h04;
	localparam logic [5:0] OFS_COMMAND = 6'h08;
	localparam logic [5:0] OFS_SRC_ENABLE = 6'h0c;
	localparam logic [5:0] OFS_MODE_CTRL = 6'h10;
	localparam logic [5:0] OFS_SYNC_CHAR = 6'h14;
	// Extended read locations, zero unless extended read is on
	localparam logic [5:0] OFS_PRIME_READBACK = 6'h18;
	localparam logic [5:0] OFS_RB_MODE = 6'h1c;
	localparam logic [5:0] OFS_RB_SRC_ENABLE = 6'h20;
	localparam logic [5:0] OFS_RB_SYNC_CHAR = 6'h24;
	localparam logic [5:0] OFS_RB_COMMAND = 6'h28;

	// Command codes in bits 2:0 of the command register
	typedef enum logic [2:0] {
		SCS_CMD_NONE = 3'b000,
		SCS_CMD_RESET_EXT = 3'b001,
		SCS_CMD_SEND_ABORT = 3'b010,
		SCS_CMD_ENTER_HUNT = 3'b011,
		SCS_CMD_RESET_UNDERRUN = 3'b100,
		SCS_CMD_ERROR_RESET = 3'b101
	} scs_cmd_e;

	// Channel operating modes in the mode control register
	typedef enum logic [1:0] {
		SCS_MODE_ASYNC = 2'b00,
		SCS_MODE_CHAR_SYNC = 2'b01,
		SCS_MODE_FRAME = 2'b10,
		SCS_MODE_EXT_SYNC = 2'b11
	} scs_mode_e;

	// Mode control register fields
	localparam int MC_PRIME_PTR = 0;
	localparam int MC_MODE_LSB = 1;
	localparam int MC_XTAL = 3;
	localparam int MC_RX_EN = 4;
	localparam int MC_TX_EN = 5;
	localparam logic [7:0] MC_RESET = 8'h00;

	// Source enable register fields
	localparam int SE_BREAK = 7;
	localparam int SE_UNDERRUN = 6;
	localparam int SE_CTS = 5;
	localparam int SE_SYNC = 4;
	localparam int SE_DCD = 3;
	localparam int SE_ZERO = 1;
	localparam logic [7:0] SE_RESET = 8'hf8;

	// Prime register field and reset
	localparam int PR_EXT_READ = 6;
	localparam logic [7:0] PR_RESET = 8'h00;

	// Line status bit positions
	localparam int LS_RX_AVAIL = 0;
	localparam int LS_TX_EMPTY = 2;
	localparam logic [7:0] LS_RESET = 8'h44;

	// Special receive status bit positions
	localparam int SR_EOF = 7;
	localparam int SR_CRC_FE = 6;
	localparam int SR_OVERRUN = 5;
endpackage : scs_pkg

// ---- tb/scs_far_side.sv ----
// Behavioural modem lines and external sync logic facing the status block
`timescale 1ns/100ps
module scs_far_side (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Requests from the bench
	input wire logic cts_on,
	input wire logic carrier_on,
	input wire logic sync_on,
	input wire logic ext_hunt,
	input wire logic ext_align,
	// Device side sync driver
	input wire logic sync_pin_n_out,
	input wire logic sync_pin_oe,
	// Pins seen by the device
	output logic cts_pin_n,
	output logic carrier_detect_pin_n,
	output logic sync_pin_n_in
);
	logic hunting;
	logic [1:0] align_seen;
	logic ext_n;

	// Modem lines are active low
	assign cts_pin_n = ~cts_on;
	assign carrier_detect_pin_n = ~carrier_on;

	// Hunt holds the pin high; the pin drops on the second edge after
	// the last bit, so the device never sees a half-aligned character
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			hunting <= 1'b0;
			align_seen <= 2'b00;
		end else begin
			align_seen <= {align_seen[0], ext_align & hunting};
			if (ext_hunt) begin
				hunting <= 1'b1;
			end else if (align_seen[1]) begin
				hunting <= 1'b0;
			end
		end
	end

	// Device drive wins while it owns the pin
	assign ext_n = hunting ? 1'b1 : ~sync_on;
	assign sync_pin_n_in = sync_pin_oe ? sync_pin_n_out : ext_n;
endmodule : scs_far_side

// ---- tb/testbench.sv ----
// Self-checking bench for the channel status register block
`timescale 1ns/100ps
module testbench;
	localparam logic [5:0] LS = scs_pkg::OFS_LINE_STATUS;
	localparam logic [5:0] SR = scs_pkg::OFS_SPECIAL_RX;
	localparam logic [5:0] SE = scs_pkg::OFS_SRC_ENABLE;
	localparam logic [5:0] MC = scs_pkg::OFS_MODE_CTRL;
	localparam logic [5:0] SC = scs_pkg::OFS_SYNC_CHAR;
	logic core_clk, sys_rst, avs_read, avs_write, avs_waitrequest;
	logic [5:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0] avs_byteenable;
	logic rx_char_avail, tx_entry_free, tx_crc_busy, tx_underrun, baud_zero;
	logic rx_break, rx_abort, rx_sync_found, rx_open_flag, rx_close_flag;
	logic rx_char_done, rx_char_err, rx_head_overrun, rx_overrun_read;
	logic cts_pin_n, carrier_detect_pin_n, sync_pin_n_in, sync_pin_n_out;
	logic sync_pin_oe, interrupt_pending_flag;
	logic cts_on, carrier_on, sync_on, ext_hunt, ext_align;
	logic [7:0] q;
	int fails, check_count;

	scs_status_regs uut (.core_clk, .sys_rst, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
		.avs_waitrequest, .rx_char_avail, .tx_entry_free, .tx_crc_busy,
		.tx_underrun, .baud_zero, .rx_break, .rx_abort, .rx_sync_found,
		.rx_open_flag, .rx_close_flag, .rx_char_done, .rx_char_err,
		.rx_head_overrun, .rx_overrun_read, .cts_pin_n, .carrier_detect_pin_n,
		.sync_pin_n_in, .sync_pin_n_out, .sync_pin_oe, .interrupt_pending_flag);
	scs_far_side far (.core_clk, .sys_rst, .cts_on, .carrier_on, .sync_on,
		.ext_hunt, .ext_align, .sync_pin_n_out, .sync_pin_oe, .cts_pin_n,
		.carrier_detect_pin_n, .sync_pin_n_in);

	// 25 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : give_verdict

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("FAIL %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic st;
		repeat (6) @(posedge core_clk);
	endtask : st

	// Hardware reset, also returning all levels to idle
	task automatic rs;
		sys_rst <= 1'b1;
		{rx_char_avail, tx_crc_busy, baud_zero, rx_break, rx_abort} <= 5'h00;
		{rx_char_err, rx_head_overrun, cts_on, carrier_on, sync_on} <= 5'h00;
		tx_entry_free <= 1'b1;
		avs_byteenable <= 4'hf;
		repeat (5) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
	endtask : rs

	// One Avalon-MM access; the request holds until waitrequest is low
	task automatic bus(input logic w, input logic [5:0] a,
		input logic [7:0] d, output logic [7:0] r);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= {24'h000000, d};
		avs_read <= ~w;
		avs_write <= w;
		@(posedge core_clk);
		while (avs_waitrequest !== 1'b0 && n < 50) begin
			n++;
			@(posedge core_clk);
		end
		if (n == 50) begin
			fails++;
			$display("FAIL %0t: bus timeout", $time);
		end
		r = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge core_clk);
	endtask : bus

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic er(input logic [5:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00, q);
		check(q, e);
	endtask : er

	// Reads one register and compares a single bit
	task automatic eb(input logic [5:0] a, input int i, input logic e);
		bus(1'b0, a, 8'h00, q);
		check({7'h00, q[i]}, {7'h00, e});
	endtask : eb

	task automatic irq(input logic e);
		check({7'h00, interrupt_pending_flag}, {7'h00, e});
	endtask : irq

	task automatic cmd(input scs_pkg::scs_cmd_e c);
		wr(scs_pkg::OFS_COMMAND, {5'h00, c});
		st();
	endtask : cmd

	function automatic logic [7:0] mw(input scs_pkg::scs_mode_e m,
		input logic x, input logic r, input logic t);
		mw = {2'b00, t, r, x, m, 1'b0};
	endfunction : mw

	// Single-cycle receiver, transmitter or far-side align event, then let status settle
	task automatic pl(input int k);
		case (k)
			0: tx_underrun <= 1'b1;
			1: rx_sync_found <= 1'b1;
			2: rx_open_flag <= 1'b1;
			3: rx_close_flag <= 1'b1;
			4: rx_char_done <= 1'b1;
			5: rx_overrun_read <= 1'b1;
			default: ext_align <= 1'b1;
		endcase
		@(posedge core_clk);
		{tx_underrun, rx_sync_found, rx_open_flag, rx_close_flag} <= 4'h0;
		{rx_char_done, rx_overrun_read, ext_align} <= 3'h0;
		@(posedge core_clk);
		if (k == 1) check({7'h00, sync_pin_n_out}, 8'h00);
		repeat (5) @(posedge core_clk);
	endtask : pl

	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#2000000;
		fails++;
		$display("FAIL %0t: watchdog expired", $time);
		give_verdict();
	end

	// Main sequence
	initial begin
		{sys_rst, avs_read, avs_write, tx_underrun, rx_sync_found} = 5'h10;
		{rx_open_flag, rx_close_flag, rx_char_done, rx_overrun_read} = 4'h0;
		{ext_hunt, ext_align, cts_on, carrier_on, sync_on} = 5'h00;
		{rx_char_avail, tx_crc_busy, baud_zero, rx_break, rx_abort} = 5'h00;
		{rx_char_err, rx_head_overrun, tx_entry_free} = 3'b001;
		{avs_address, avs_writedata, avs_byteenable} = {6'h00, 32'h0, 4'hf};
		fails = 0;
		check_count = 0;
		@(posedge core_clk);
		rs();
		irq(1'b0);
		er(LS, scs_pkg::LS_RESET);
		er(scs_pkg::OFS_PRIME_READBACK, 8'h00);
		er(scs_pkg::OFS_RB_SRC_ENABLE, 8'h00);
		wr(MC, 8'h01);
		wr(SC, 8'h40);
		wr(SC, 8'h40);
		er(scs_pkg::OFS_RB_SYNC_CHAR, 8'h00);
		wr(MC, 8'h00);
		wr(SC, 8'h5a);
		avs_byteenable <= 4'he;
		wr(SC, 8'h11);
		avs_byteenable <= 4'hf;
		er(scs_pkg::OFS_PRIME_READBACK, 8'h40);
		er(scs_pkg::OFS_RB_SYNC_CHAR, 8'h5a);
		er(scs_pkg::OFS_RB_SRC_ENABLE, scs_pkg::SE_RESET);
		er(scs_pkg::OFS_RB_MODE, 8'h00);
		er(6'h3c, 8'h00);
		$display("test registers done");
		rx_char_avail <= 1'b1;
		tx_entry_free <= 1'b0;
		st();
		eb(LS, scs_pkg::LS_RX_AVAIL, 1'b1);
		eb(LS, scs_pkg::LS_TX_EMPTY, 1'b0);
		wr(MC, mw(scs_pkg::SCS_MODE_CHAR_SYNC, 1'b0, 1'b0, 1'b1));
		{tx_entry_free, tx_crc_busy, rx_char_avail} <= 3'b110;
		st();
		eb(LS, scs_pkg::LS_TX_EMPTY, 1'b0);
		eb(LS, scs_pkg::LS_RX_AVAIL, 1'b0);
		$display("test buffers done");
		rs();
		{cts_on, carrier_on} <= 2'b11;
		st();
		irq(1'b1);
		{cts_on, carrier_on} <= 2'b00;
		st();
		eb(LS, scs_pkg::SE_CTS, 1'b1);
		eb(LS, scs_pkg::SE_DCD, 1'b1);
		cmd(scs_pkg::SCS_CMD_RESET_EXT);
		eb(LS, scs_pkg::SE_CTS, 1'b0);
		wr(SE, 8'h00);
		cmd(scs_pkg::SCS_CMD_RESET_EXT);
		{cts_on, carrier_on} <= 2'b11;
		st();
		eb(LS, scs_pkg::SE_CTS, 1'b1);
		eb(LS, scs_pkg::SE_DCD, 1'b1);
		irq(1'b0);
		wr(SE, scs_pkg::SE_RESET);
		st();
		irq(1'b0);
		$display("test modem lines done");
		rs();
		sync_on <= 1'b1;
		st();
		eb(LS, scs_pkg::SE_SYNC, 1'b1);
		rs();
		wr(MC, mw(scs_pkg::SCS_MODE_ASYNC, 1'b1, 1'b0, 1'b0));
		cmd(scs_pkg::SCS_CMD_RESET_EXT);
		sync_on <= 1'b1;
		st();
		eb(LS, scs_pkg::SE_SYNC, 1'b0);
		irq(1'b0);
		$display("test async sync pin done");
		for (int i = 0; i < 2; i++) begin
			rs();
			if (i == 1) begin
				wr(MC, mw(scs_pkg::SCS_MODE_FRAME, 1'b0, 1'b1, 1'b0));
			end
			cmd(scs_pkg::SCS_CMD_RESET_EXT);
			{rx_abort, rx_break} <= (i == 1) ? 2'b10 : 2'b01;
			st();
			eb(LS, scs_pkg::SE_BREAK, 1'b1);
			irq(1'b1);
			cmd(scs_pkg::SCS_CMD_RESET_EXT);
			{rx_abort, rx_break} <= 2'b00;
			st();
			eb(LS, scs_pkg::SE_BREAK, 1'b0);
			irq(1'b1);
		end
		$display("test break and abort done");
		rs();
		wr(SE, 8'h02);
		cmd(scs_pkg::SCS_CMD_RESET_EXT);
		baud_zero <= 1'b1;
		st();
		eb(LS, scs_pkg::SE_ZERO, 1'b1);
		irq(1'b1);
		baud_zero <= 1'b0;
		st();
		eb(LS, scs_pkg::SE_ZERO, 1'b0);
		baud_zero <= 1'b1;
		st();
		cmd(scs_pkg::SCS_CMD_RESET_EXT);
		irq(1'b1);
		baud_zero <= 1'b0;
		cmd(scs_pkg::SCS_CMD_RESET_EXT);
		irq(1'b0);
		$display("test zero count done");
		rs();
		wr(MC, mw(scs_pkg::SCS_MODE_CHAR_SYNC, 1'b0, 1'b0, 1'b1));
		cmd(scs_pkg::SCS_CMD_RESET_EXT);
		cmd(scs_pkg::SCS_CMD_RESET_UNDERRUN);
		eb(LS, scs_pkg::SE_UNDERRUN, 1'b0);
		irq(1'b0);
		pl(0);
		eb(LS, scs_pkg::SE_UNDERRUN, 1'b1);
		irq(1'b1);
		cmd(scs_pkg::SCS_CMD_RESET_UNDERRUN);
		cmd(scs_pkg::SCS_CMD_RESET_EXT);
		irq(1'b0);
		cmd(scs_pkg::SCS_CMD_SEND_ABORT);
		eb(LS, scs_pkg::SE_UNDERRUN, 1'b1);
		irq(1'b1);
		cmd(scs_pkg::SCS_CMD_RESET_UNDERRUN);
		wr(MC, mw(scs_pkg::SCS_MODE_CHAR_SYNC, 1'b0, 1'b0, 1'b0));
		st();
		eb(LS, scs_pkg::SE_UNDERRUN, 1'b1);
		$display("test underrun done");
		rs();
		wr(MC, mw(scs_pkg::SCS_MODE_CHAR_SYNC, 1'b0, 1'b1, 1'b0));
		cmd(scs_pkg::SCS_CMD_ENTER_HUNT);
		eb(LS, scs_pkg::SE_SYNC, 1'b1);
		check({7'h00, sync_pin_oe}, 8'h01);
		cmd(scs_pkg::SCS_CMD_RESET_EXT);
		pl(1);
		eb(LS, scs_pkg::SE_SYNC, 1'b0);
		irq(1'b1);
		wr(MC, mw(scs_pkg::SCS_MODE_FRAME, 1'b0, 1'b1, 1'b0));
		cmd(scs_pkg::SCS_CMD_ENTER_HUNT);
		eb(LS, scs_pkg::SE_SYNC, 1'b1);
		pl(2);
		pl(3);
		eb(LS, scs_pkg::SE_SYNC, 1'b0);
		eb(SR, scs_pkg::SR_EOF, 1'b1);
		cmd(scs_pkg::SCS_CMD_ERROR_RESET);
		eb(SR, scs_pkg::SR_EOF, 1'b0);
		rx_char_err <= 1'b1;
		pl(4);
		eb(SR, scs_pkg::SR_CRC_FE, 1'b1);
		rx_char_err <= 1'b0;
		pl(4);
		eb(SR, scs_pkg::SR_CRC_FE, 1'b0);
		rx_head_overrun <= 1'b1;
		st();
		eb(SR, scs_pkg::SR_OVERRUN, 1'b1);
		rx_head_overrun <= 1'b0;
		pl(5);
		eb(SR, scs_pkg::SR_OVERRUN, 1'b1);
		cmd(scs_pkg::SCS_CMD_ERROR_RESET);
		eb(SR, scs_pkg::SR_OVERRUN, 1'b0);
		wr(MC, mw(scs_pkg::SCS_MODE_FRAME, 1'b0, 1'b0, 1'b0));
		st();
		eb(LS, scs_pkg::SE_SYNC, 1'b1);
		wr(MC, mw(scs_pkg::SCS_MODE_ASYNC, 1'b0, 1'b1, 1'b0));
		pl(3);
		eb(SR, scs_pkg::SR_EOF, 1'b0);
		$display("test hunt and frame done");
		rs();
		wr(MC, mw(scs_pkg::SCS_MODE_EXT_SYNC, 1'b0, 1'b1, 1'b0));
		ext_hunt <= 1'b1;
		@(posedge core_clk);
		ext_hunt <= 1'b0;
		sync_on <= 1'b1;
		cmd(scs_pkg::SCS_CMD_ENTER_HUNT);
		eb(LS, scs_pkg::SE_SYNC, 1'b0);
		pl(6);
		eb(LS, scs_pkg::SE_SYNC, 1'b1);
		$display("test external sync done");
		give_verdict();
	end
endmodule : testbench
